/* File: pkg/prs_defs.vh */
// constants for the reference switchover and holdover control block
`ifndef PRS_DEFS_VH
`define PRS_DEFS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define PRS_ADDR_W          10
`define PRS_OFS_REF_CTRL    10'h01c
`define PRS_OFS_HOLD_CTRL   10'h01d
`define PRS_OFS_STATUS      10'h01f

// ****************************************************************
// reference_selection_control fields
// ****************************************************************
`define PRS_RC_NO_DEGLITCH  7
`define PRS_RC_SEL_SECOND   6
`define PRS_RC_USE_PIN      5
`define PRS_RC_AUTO         4
`define PRS_RC_STAY_SECOND  3
`define PRS_RC_PWR_SECOND   2
`define PRS_RC_PWR_FIRST    1
`define PRS_RC_DIFF         0
`define PRS_RC_RESET        8'h00

// ****************************************************************
// holdover_and_lock_control fields
// ****************************************************************
`define PRS_HC_NO_READBACK  4
`define PRS_HC_CMP_EN       3
`define PRS_HC_HOLD_EN_HI   2
`define PRS_HC_EXT_HOLD     1
`define PRS_HC_HOLD_EN_LO   0
`define PRS_HC_MASK         8'h1f
`define PRS_HC_RESET        8'h00

// ****************************************************************
// pll_status_readback fields
// ****************************************************************
`define PRS_ST_CAL_DONE     6
`define PRS_ST_HOLD_ACT     5
`define PRS_ST_SEL_SECOND   4
`define PRS_ST_VCO_ABOVE    3
`define PRS_ST_SECOND_ABOVE 2
`define PRS_ST_FIRST_ABOVE  1
`define PRS_ST_LOCK         0

// ****************************************************************
// timing
// ****************************************************************
`define PRS_CLK_MHZ         200
`define PRS_DEGLITCH_NS     50
`define PRS_DEGLITCH_CYC    ((`PRS_DEGLITCH_NS*`PRS_CLK_MHZ+999)/1000)

`endif

/* File: src/prs_ref_ctrl.v */
// reference selection, switchover deglitch and holdover control logic
`timescale 1ns/100ps
`include "prs_defs.vh"

// ****************************************************************
// Summary of operation
// - control bit 7 set disables the switchover deglitch; clear keeps it.
// - with pin select clear, bit 6 picks first (0) or second (1) ref.
// - in manual mode bit 5 picks register bit (0) or select pin (1).
// - bit 4 selects manual or auto switchover; auto needs single-ended.
// - bit 3 clear returns to first ref when it is good; set stays.
// - with automatic off, bit 2 powers the second receiver on or off.
// - with automatic off, bit 1 powers the first receiver on or off.
// - bit 0 picks single-ended (0) or differential (1) reference mode.
// - reference control register resets to all zeros.
// - holdover register bit 4 set blanks status readback; clear enables it.
// - bit 3 enables lock pin comparator; disabled, pin counts as high.
// - automatic holdover uses the lock pin to judge earlier lock.
// - holdover works only with bits 2 and 0 both set; both reset low.
// - bit 1 set hands holdover to the external pin, else internal circuit.
// - status bit 6 reads 1 when VCO calibration has finished.
// - status bit 5 shows holdover state active, not merely enabled.
// - status bit 4 shows the reference feeding the PLL, 1 for second.
// - status bit 3 reads 1 when the VCO frequency is above threshold.
// - status bit 0 shows digital lock indication.
// - status bits 2 and 1 show second and first ref above threshold.
// ****************************************************************

module prs_ref_ctrl (
  input  wire                     sys_clk,
  input  wire                     sys_rst,
  input  wire [`PRS_ADDR_W-1:0]   reg_addr,
  input  wire [7:0]               reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [7:0]               reg_rdata_q,
  input  wire                     ref_sel_pin,
  input  wire                     ext_hold_pin,
  input  wire                     lock_indicator_pin,
  input  wire                     digital_lock_indication,
  input  wire                     first_ref_above,
  input  wire                     second_ref_above,
  input  wire                     vco_above,
  input  wire                     vco_cal_done,
  output reg                      pll_ref_second_q,
  output reg                      ref_mute_q,
  output reg                      first_ref_pwr_q,
  output reg                      second_ref_pwr_q,
  output reg                      diff_mode_q,
  output reg                      lock_cmp_en_q,
  output reg                      holdover_active_q
);

  // ****************************************************************
  // local constants
  // ****************************************************************
  // the gap count must fit the four-bit counter of the deglitch
  localparam integer DG_INT = `PRS_DEGLITCH_CYC;
  localparam [3:0] DG_CYC   = DG_INT[3:0];
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_ARMED = 3'h2;
  localparam [2:0] ST_HOLD  = 3'h4;
  localparam       N_SYNC   = 8;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // every status line comes from analog or pin logic on no known clock
  // each line costs two cycles of latency before any logic sees it;
  // the order of the vector sets the index of each line below
  wire [N_SYNC-1:0] raw_in;
  reg  [N_SYNC-1:0] meta_q;
  reg  [N_SYNC-1:0] sync_q;

  assign raw_in = {vco_cal_done, vco_above, second_ref_above,
                   first_ref_above, digital_lock_indication,
                   lock_indicator_pin, ext_hold_pin, ref_sel_pin};

  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  wire sel_pin_s    = sync_q[0];
  wire ext_hold_s   = sync_q[1];
  wire lock_pin_s   = sync_q[2];
  wire dlock_s      = sync_q[3];
  wire first_ok_s   = sync_q[4];
  wire second_ok_s  = sync_q[5];
  wire vco_above_s  = sync_q[6];
  wire cal_done_s   = sync_q[7];

  // ****************************************************************
  // control registers
  // ****************************************************************
  reg [7:0] ref_ctrl_q;
  reg [7:0] hold_ctrl_q;

  // writes to the status offset or to unmapped offsets are dropped;
  // bits 7:5 of the holdover register are not stored and read back 0
  wire wr_ref  = reg_wr && (reg_addr == `PRS_OFS_REF_CTRL);
  wire wr_hold = reg_wr && (reg_addr == `PRS_OFS_HOLD_CTRL);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ref_ctrl_q  <= `PRS_RC_RESET;
      hold_ctrl_q <= `PRS_HC_RESET;
    end else begin
      if (wr_ref)
        ref_ctrl_q <= reg_wdata;
      if (wr_hold)
        hold_ctrl_q <= reg_wdata & `PRS_HC_MASK;
    end
  end

  wire no_deglitch = ref_ctrl_q[`PRS_RC_NO_DEGLITCH];
  wire reg_second  = ref_ctrl_q[`PRS_RC_SEL_SECOND];
  wire use_pin     = ref_ctrl_q[`PRS_RC_USE_PIN];
  wire stay_second = ref_ctrl_q[`PRS_RC_STAY_SECOND];
  wire diff_mode   = ref_ctrl_q[`PRS_RC_DIFF];
  // automatic switchover is only meaningful with two single-ended inputs
  wire auto_mode   = ref_ctrl_q[`PRS_RC_AUTO] & ~diff_mode;

  wire no_readback = hold_ctrl_q[`PRS_HC_NO_READBACK];
  wire cmp_en      = hold_ctrl_q[`PRS_HC_CMP_EN];
  wire ext_hold    = hold_ctrl_q[`PRS_HC_EXT_HOLD];
  wire hold_en     = hold_ctrl_q[`PRS_HC_HOLD_EN_HI] &
                     hold_ctrl_q[`PRS_HC_HOLD_EN_LO];

  // ****************************************************************
  // automatic switchover
  // ****************************************************************
  // the first reference is the preferred one; the second is a fallback
  // taken when the first is reported bad, and kept while bit 3 is set
  // leaving automatic mode clears the fallback so manual takes over
  reg auto_second_q;
  reg auto_second_d;

  always @* begin
    auto_second_d = auto_second_q;
    if (!auto_mode)
      auto_second_d = 1'b0;
    else if (!auto_second_q && !first_ok_s)
      auto_second_d = 1'b1;
    else if (auto_second_q && first_ok_s && !stay_second)
      auto_second_d = 1'b0;
  end

  always @(posedge sys_clk) begin
    if (sys_rst)
      auto_second_q <= 1'b0;
    else
      auto_second_q <= auto_second_d;
  end

  // ****************************************************************
  // target reference
  // ****************************************************************
  // differential mode has one input pair, which always feeds as first
  reg want_second;

  always @* begin
    want_second = 1'b0;
    if (diff_mode)
      want_second = 1'b0;
    else if (auto_mode)
      want_second = auto_second_q;
    else if (use_pin)
      want_second = sel_pin_s;
    else
      want_second = reg_second;
  end

  // ****************************************************************
  // switchover deglitch
  // ****************************************************************
  // the reference is muted for a fixed gap so that the PLL never sees
  // a runt edge made from half of each input; costs a few missed edges
  reg [3:0] dg_cnt_q;
  reg       busy_q;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pll_ref_second_q <= 1'b0;
      ref_mute_q       <= 1'b0;
      dg_cnt_q         <= 4'h0;
      busy_q           <= 1'b0;
    end else if (no_deglitch) begin
      pll_ref_second_q <= want_second;
      ref_mute_q       <= 1'b0;
      dg_cnt_q         <= 4'h0;
      busy_q           <= 1'b0;
    end else if (busy_q) begin
      // the latest target is taken at the end, so a change inside the
      // gap is not lost
      if (dg_cnt_q == DG_CYC - 4'h1) begin
        pll_ref_second_q <= want_second;
        ref_mute_q       <= 1'b0;
        busy_q           <= 1'b0;
        dg_cnt_q         <= 4'h0;
      end else begin
        dg_cnt_q <= dg_cnt_q + 4'h1;
      end
    end else if (want_second != pll_ref_second_q) begin
      ref_mute_q <= 1'b1;
      busy_q     <= 1'b1;
      dg_cnt_q   <= 4'h0;
    end
  end

  // ****************************************************************
  // receiver power and mode outputs
  // ****************************************************************
  // in automatic mode both receivers must run so that either can be
  // monitored; the power bits only take effect in manual mode
  // differential mode and comparator enable are plain registered copies
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      first_ref_pwr_q  <= 1'b0;
      second_ref_pwr_q <= 1'b0;
      diff_mode_q      <= 1'b0;
      lock_cmp_en_q    <= 1'b0;
    end else begin
      if (auto_mode) begin
        first_ref_pwr_q  <= 1'b1;
        second_ref_pwr_q <= 1'b1;
      end else begin
        first_ref_pwr_q  <= ref_ctrl_q[`PRS_RC_PWR_FIRST];
        second_ref_pwr_q <= ref_ctrl_q[`PRS_RC_PWR_SECOND];
      end
      diff_mode_q   <= diff_mode;
      lock_cmp_en_q <= cmp_en;
    end
  end

  // ****************************************************************
  // holdover controller
  // ****************************************************************
  // comparator off means the controller assumes an earlier lock
  wire lock_seen  = cmp_en ? lock_pin_s : 1'b1;
  // holdover judges the reference that actually feeds the PLL
  wire sel_ok     = pll_ref_second_q ? second_ok_s : first_ok_s;

  // idle waits for lock, armed watches the selected reference, and
  // hold lasts until that reference is good again
  reg [2:0] hst_q;
  reg [2:0] hst_d;

  always @* begin
    hst_d = hst_q;
    if (!hold_en || ext_hold) begin
      hst_d = ST_IDLE;
    end else begin
      case (hst_q)
        ST_IDLE: begin
          if (dlock_s && lock_seen)
            hst_d = ST_ARMED;
        end
        ST_ARMED: begin
          if (!sel_ok && lock_seen)
            hst_d = ST_HOLD;
          else if (!dlock_s && sel_ok)
            hst_d = ST_IDLE;
        end
        ST_HOLD: begin
          if (sel_ok)
            hst_d = ST_IDLE;
        end
        default: begin
          hst_d = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      hst_q             <= ST_IDLE;
      holdover_active_q <= 1'b0;
    end else begin
      hst_q <= hst_d;
      if (!hold_en)
        holdover_active_q <= 1'b0;
      // external control bypasses the state machine: the pin is the state
      else if (ext_hold)
        holdover_active_q <= ext_hold_s;
      else
        holdover_active_q <= (hst_d == ST_HOLD);
    end
  end

  // ****************************************************************
  // register readback
  // ****************************************************************
  // bit 7 of the status has no meaning and reads 0
  reg [7:0] status;
  reg [7:0] rd_mux;

  always @* begin
    status = 8'h00;
    status[`PRS_ST_CAL_DONE]     = cal_done_s;
    status[`PRS_ST_HOLD_ACT]     = holdover_active_q;
    status[`PRS_ST_SEL_SECOND]   = pll_ref_second_q;
    status[`PRS_ST_VCO_ABOVE]    = vco_above_s;
    status[`PRS_ST_SECOND_ABOVE] = second_ok_s;
    status[`PRS_ST_FIRST_ABOVE]  = first_ok_s;
    status[`PRS_ST_LOCK]         = dlock_s;
  end

  always @* begin
    rd_mux = 8'h00;
    // any offset outside the map reads 0
    case (reg_addr)
      `PRS_OFS_REF_CTRL:  rd_mux = ref_ctrl_q;
      `PRS_OFS_HOLD_CTRL: rd_mux = hold_ctrl_q;
      `PRS_OFS_STATUS:    rd_mux = no_readback ? 8'h00 : status;
      default:            rd_mux = 8'h00;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always @(posedge sys_clk) begin
    if (sys_rst)
      reg_rdata_q <= 8'h00;
    else if (reg_rd)
      reg_rdata_q <= rd_mux;
    else
      reg_rdata_q <= 8'h00;
  end

endmodule

/* File: tb/prs_pin_model.sv */
// model of the reference sources, lock detector and host pins
`timescale 1ns/100ps
module prs_pin_model #(
  parameter CAL_CYC = 40
) (
  input  wire       sys_clk,
  input  wire       cal_start,
  input  wire [6:0] pin_want,
  output wire [7:0] pins
);
  // ****************************************************************
  // pins change one clock after the request, like a slow source
  // ****************************************************************
  reg [6:0] pin_q     = 7'h00;
  reg [7:0] cal_cnt_q = CAL_CYC;
  always @(posedge sys_clk) begin
    pin_q <= pin_want;
    if (cal_start) begin
      cal_cnt_q <= CAL_CYC;
    end else if (cal_cnt_q != 8'h00) begin
      cal_cnt_q <= cal_cnt_q - 8'h01;
    end
  end
  assign pins = {cal_cnt_q == 8'h00, pin_q};
endmodule

/* File: tb/prs_ref_ctrl_props.sv */
// assertions on the reference control block ports
`timescale 1ns/100ps
`include "prs_defs.vh"
module prs_ref_ctrl_props (
  input wire                   sys_clk,
  input wire                   sys_rst,
  input wire [`PRS_ADDR_W-1:0] reg_addr,
  input wire [7:0]             reg_wdata,
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [7:0]             reg_rdata_q,
  input wire                   ext_hold_pin,
  input wire                   pll_ref_second_q,
  input wire                   ref_mute_q,
  input wire                   first_ref_pwr_q,
  input wire                   second_ref_pwr_q,
  input wire                   diff_mode_q,
  input wire                   lock_cmp_en_q,
  input wire                   holdover_active_q
);
  // ****************************************************************
  // register mirrors; settled means no config write for 15 cycles
  // ****************************************************************
  reg [7:0] rc_q;
  reg [7:0] hc_q;
  reg [3:0] age_q;
  wire rc_wr = reg_wr && reg_addr == `PRS_OFS_REF_CTRL;
  wire hc_wr = reg_wr && reg_addr == `PRS_OFS_HOLD_CTRL;
  wire st_rd = reg_rd && reg_addr == `PRS_OFS_STATUS;
  wire settled = age_q == 4'hf;
  wire ext_on = settled && hc_q[2] && hc_q[0] && hc_q[1];
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rc_q <= 8'h00;
      hc_q <= 8'h00;
      age_q <= 4'h0;
    end else begin
      if (rc_wr) rc_q <= reg_wdata;
      if (hc_wr) hc_q <= reg_wdata & `PRS_HC_MASK;
      if (rc_wr || hc_wr) age_q <= 4'h0;
      else if (!settled) age_q <= age_q + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data not zero outside read");
  mute_len_a: assert property (
    $rose(ref_mute_q) |-> ref_mute_q[*8] ##1 ref_mute_q[*2] ##1 !ref_mute_q)
    else $error("deglitch gap length wrong");
  ref_gated_a: assert property (
    $changed(pll_ref_second_q) && !$past(rc_q[7]) |-> $fell(ref_mute_q))
    else $error("reference changed outside deglitch gap");
  pwr_manual_a: assert property (
    settled && !rc_q[4] |-> first_ref_pwr_q == rc_q[1]
      && second_ref_pwr_q == rc_q[2])
    else $error("receiver power wrong");
  diff_ref_a: assert property (
    settled |-> diff_mode_q == rc_q[0] && !(rc_q[0] && pll_ref_second_q))
    else $error("differential mode wrong");
  cmp_en_a: assert property (settled |-> lock_cmp_en_q == hc_q[3])
    else $error("comparator enable wrong");
  hold_off_a: assert property (
    settled && !(hc_q[2] && hc_q[0]) |-> !holdover_active_q)
    else $error("holdover active while disabled");
  hold_ext_a: assert property (
    ($stable(ext_hold_pin) && ext_on)[*4] |->
      holdover_active_q == ext_hold_pin)
    else $error("external holdover not followed");
  rd_block_a: assert property (
    st_rd && hc_q[4] |=> reg_rdata_q == 8'h00)
    else $error("status readable while disabled");
  rd_state_a: assert property (
    st_rd && !hc_q[4] |=> reg_rdata_q[5:4] ==
      {$past(holdover_active_q), $past(pll_ref_second_q)})
    else $error("status state bits wrong");
  rc_back_a: assert property (
    reg_rd && reg_addr == `PRS_OFS_REF_CTRL |=> reg_rdata_q == $past(rc_q))
    else $error("reference control readback wrong");
endmodule
bind prs_ref_ctrl prs_ref_ctrl_props i_prs_ref_ctrl_props (
  .sys_clk           (sys_clk),
  .sys_rst           (sys_rst),
  .reg_addr          (reg_addr),
  .reg_wdata         (reg_wdata),
  .reg_wr            (reg_wr),
  .reg_rd            (reg_rd),
  .reg_rdata_q       (reg_rdata_q),
  .ext_hold_pin      (ext_hold_pin),
  .pll_ref_second_q  (pll_ref_second_q),
  .ref_mute_q        (ref_mute_q),
  .first_ref_pwr_q   (first_ref_pwr_q),
  .second_ref_pwr_q  (second_ref_pwr_q),
  .diff_mode_q       (diff_mode_q),
  .lock_cmp_en_q     (lock_cmp_en_q),
  .holdover_active_q (holdover_active_q)
);

/* File: tb/tb_prs_ref_ctrl.sv */
// self-checking bench for the reference control block
`timescale 1ns/100ps
`include "prs_defs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
module tb_prs_ref_ctrl;
  reg        sys_clk   = 1'b0;
  reg        sys_rst   = 1'b1;
  reg  [9:0] reg_addr  = 10'h000;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr    = 1'b0;
  reg        reg_rd    = 1'b0;
  reg  [6:0] pin_d     = 7'h00;
  reg        cal_go    = 1'b0;
  reg  [7:0] v;
  reg  [9:0] tab [0:5];
  wire [7:0] rdata;
  wire [7:0] pins;
  wire       second_reference_input, mute, p1, p2, dm, ce, hold;
  integer    compares = 0, failures = 0, cyc = 0, i, n;
  always #2.5 sys_clk = ~sys_clk;
  prs_pin_model i_prs_pin_model (.sys_clk(sys_clk), .cal_start(cal_go),
    .pin_want(pin_d), .pins(pins));
  prs_ref_ctrl i_prs_ref_ctrl (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(rdata), .ref_sel_pin(pins[6]),
    .ext_hold_pin(pins[5]), .lock_indicator_pin(pins[4]),
    .digital_lock_indication(pins[3]), .first_ref_above(pins[2]),
    .second_ref_above(pins[1]), .vco_above(pins[0]),
    .vco_cal_done(pins[7]), .pll_ref_second_q(second_reference_input), .ref_mute_q(mute),
    .first_ref_pwr_q(p1), .second_ref_pwr_q(p2), .diff_mode_q(dm),
    .lock_cmp_en_q(ce), .holdover_active_q(hold));
  // ****************************************************************
  // bus tasks and expectations
  // ****************************************************************
  task wr(input [9:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rdc(input [9:0] a, input [7:0] e);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 `CHK(rdata, e)
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge sys_clk);
      #1;
    end
  endtask
  function [7:0] st_exp(input [6:0] p, input c, input h, input r);
    st_exp = {1'b0, c, h, r, p[0], p[1], p[2], p[3]};
  endfunction
  function exp_ref(input [7:0] rc, input pin);
    exp_ref = rc[0] ? 1'b0 : rc[5] ? pin : rc[6];
  endfunction
  task give_verdict;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // hang guard: the whole run needs well under 3000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    v = 8'($urandom(32'h18d6ac4a));
    tab[0] = 10'h042; tab[1] = 10'h041; tab[2] = 10'h042;
    tab[3] = 10'h061; tab[4] = 10'h063; tab[5] = 10'h044;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(1);
    `CHK({second_reference_input, mute, p1, p2, dm, ce, hold}, 7'h00)
    rdc(`PRS_OFS_REF_CTRL, 8'h00);
    rdc(`PRS_OFS_HOLD_CTRL, 8'h00);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      v = 8'($urandom) | 8'h80;
      wr(`PRS_OFS_REF_CTRL, v);
      rdc(`PRS_OFS_REF_CTRL, v);
      v = 8'($urandom);
      wr(`PRS_OFS_HOLD_CTRL, v);
      wr(`PRS_OFS_STATUS, v);
      rdc(`PRS_OFS_HOLD_CTRL, v & `PRS_HC_MASK);
      rdc(10'h3ff, 8'h00);
    end
    wr(`PRS_OFS_HOLD_CTRL, 8'h00);
    $display("test registers done");
    // manual selection, receiver power and status with random pins
    for (n = 0; n < 32; n++) begin
      v = {1'b1, n[0], n[1], 2'b00, n[3], n[4], n[2]};
      pin_d <= 7'($urandom);
      wr(`PRS_OFS_REF_CTRL, v);
      tick(8);
      `CHK(second_reference_input, exp_ref(v, pin_d[6]))
      `CHK({p1, p2, dm}, {v[1], v[2], v[0]})
      rdc(`PRS_OFS_STATUS,
        st_exp(pin_d, 1'b1, 1'b0, exp_ref(v, pin_d[6])));
    end
    $display("test manual done");
    wr(`PRS_OFS_REF_CTRL, 8'h00);
    tick(15);
    wr(`PRS_OFS_REF_CTRL, 8'h40);
    n = 0;
    repeat (30) begin
      @(posedge sys_clk);
      #1 if (mute === 1'b1) n++;
    end
    `CHK(n, 10)
    `CHK(second_reference_input, 1'b1)
    $display("test deglitch done");
    // automatic switchover table: control bits 3 to 0 (bit 4 always set), first ref good or bad per entry
    for (i = 0; i < 6; i++) begin
      pin_d <= {4'h0, tab[i][1], 2'h0};
      wr(`PRS_OFS_REF_CTRL, {4'h1, tab[i][5:2]});
      tick(20);
      `CHK(second_reference_input, tab[i][0])
      `CHK({p1, p2}, tab[i][2] ? {tab[i][3], tab[i][4]} : 2'h3)
    end
    $display("test automatic done");
    wr(`PRS_OFS_HOLD_CTRL, 8'h07);
    pin_d <= 7'h20;
    tick(16);
    `CHK(hold, 1'b1)
    rdc(`PRS_OFS_STATUS, st_exp(pin_d, 1'b1, 1'b1, 1'b0));
    wr(`PRS_OFS_HOLD_CTRL, 8'h06);
    tick(8);
    `CHK(hold, 1'b0)
    wr(`PRS_OFS_HOLD_CTRL, 8'h16);
    rdc(`PRS_OFS_STATUS, 8'h00);
    $display("test external holdover done");
    wr(`PRS_OFS_HOLD_CTRL, 8'h00);
    wr(`PRS_OFS_REF_CTRL, 8'h00);
    cal_go <= 1'b1;
    tick(1);
    cal_go <= 1'b0;
    tick(8);
    rdc(`PRS_OFS_STATUS, st_exp(pin_d, 1'b0, 1'b0, 1'b0));
    tick(50);
    // holdover is enabled only once calibration has finished
    `CHK(pins[7], 1'b1)
    pin_d <= 7'h0c;
    wr(`PRS_OFS_HOLD_CTRL, 8'h0d);
    tick(8);
    `CHK(ce, 1'b1)
    pin_d <= 7'h08;
    tick(8);
    `CHK(hold, 1'b0)
    pin_d <= 7'h0c;
    wr(`PRS_OFS_HOLD_CTRL, 8'h05);
    tick(8);
    pin_d <= 7'h08;
    tick(8);
    `CHK(hold, 1'b1)
    pin_d <= 7'h0c;
    tick(8);
    `CHK(hold, 1'b0)
    $display("test internal holdover done");
    give_verdict;
  end
endmodule
